// file: logic/tio_params.svh
// named constants for the timer pin-function and event-flag block
`ifndef TIO_PARAMS_SVH
`define TIO_PARAMS_SVH

// ---------------------------------------------------------------
// register selects on the internal 8-bit bus
// ---------------------------------------------------------------
`define TIO_SEL_CONTROL      2'h0
`define TIO_SEL_FLAGS        2'h1
`define TIO_SEL_ENABLES      2'h2
`define TIO_UNMAPPED_READ    8'hff

// ---------------------------------------------------------------
// reset values and reserved-bit patterns
// ---------------------------------------------------------------
`define TIO_CONTROL_RESET    8'h88
`define TIO_FLAGS_RESET      8'hf8
`define TIO_ENABLES_RESET    8'hf8
`define TIO_FLAGS_FILL       5'h1f
`define TIO_ROLE_RESET       3'h0

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TIO_FIELD_A_LSB      0
`define TIO_FIELD_B_LSB      4
`define TIO_FIELD_WIDTH      3
`define TIO_ROLE_CAPTURE_BIT 2
`define TIO_FLAG_A           0
`define TIO_FLAG_B           1
`define TIO_FLAG_WRAP        2
`define TIO_FLAG_COUNT       3

// ---------------------------------------------------------------
// pin actions and capture edges (low two bits of a role field)
// ---------------------------------------------------------------
`define TIO_ACT_NONE         2'h0
`define TIO_ACT_LOW          2'h1
`define TIO_ACT_HIGH         2'h2
`define TIO_ACT_TOGGLE       2'h3
`define TIO_EDGE_RISE        2'h0
`define TIO_EDGE_FALL        2'h1
`define TIO_EDGE_BOTH_BIT    1

// ---------------------------------------------------------------
// channel numbers with special behaviour
// ---------------------------------------------------------------
`define TIO_CH_NO_TOGGLE     2
`define TIO_CH_PHASE         2
`define TIO_CH_PAIR_LO       3
`define TIO_CH_PAIR_HI       4
`define TIO_CH_DMA_LAST      3

`endif

// file: logic/tio_pkg.sv
// types shared by the timer pin-function and event-flag block
`default_nettype none
package tio_pkg;

  // one cycle of the internal 8-bit register bus
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] sel;
    logic [7:0] wdata;
  } tio_bus_type;

  // counter activity reported by the channel counter
  typedef struct packed {
    logic        count_tick;
    logic        wrap_up;
    logic        wrap_down;
    logic [15:0] value;
  } tio_count_type;

  // mode selections of the surrounding timer unit
  typedef struct packed {
    logic phase_count_select;
    logic combined_mode_hi;
    logic combined_mode_lo;
  } tio_mode_type;

  // interrupt requests toward the cpu
  typedef struct packed {
    logic wrap;
    logic b;
    logic a;
  } tio_irq_type;

endpackage
`default_nettype wire

// file: logic/tio_flags_ctl.sv
// one timer channel: pin-function control, event flags, irq enables
`timescale 1ns/1ps
`default_nettype none
`include "tio_params.svh"

module tio_flags_ctl #(
  parameter int CHANNEL_INDEX = 0
) (
  // clock and reset
  input  wire  logic                   clk,
  input  wire  logic                   reset,
  input  wire  logic                   standby,
  // internal register bus
  input  wire  tio_pkg::tio_bus_type   bus,
  output var   logic [7:0]             rdata,
  // counter and mode state from the timer unit
  input  wire  tio_pkg::tio_count_type channel_counter,
  input  wire  logic [15:0]            general_reg_a,
  input  wire  logic [15:0]            general_reg_b,
  input  wire  tio_pkg::tio_mode_type  mode,
  input  wire  logic                   dma_start_a,
  // compare/capture pins, index 0 is pin A and 1 is pin B
  input  wire  logic [1:0]             pin_in,
  output var   logic [1:0]             pin_out,
  output var   logic [1:0]             pin_oe,
  // capture load strobes toward the general registers
  output var   logic [1:0]             capture_load,
  // interrupt requests
  output var   tio_pkg::tio_irq_type   irq
);

  // ---------------------------------------------------------------
  // channel-dependent constants
  // ---------------------------------------------------------------
  localparam logic IS_PAIR      = (CHANNEL_INDEX == `TIO_CH_PAIR_LO) ||
                                  (CHANNEL_INDEX == `TIO_CH_PAIR_HI);
  localparam logic IS_PHASE_CH  = (CHANNEL_INDEX == `TIO_CH_PHASE);
  localparam logic NO_TOGGLE    = (CHANNEL_INDEX == `TIO_CH_NO_TOGGLE);
  localparam logic HAS_DMA_CLR  = (CHANNEL_INDEX <= `TIO_CH_DMA_LAST);
  // all of the above fold away per instance, so absent features cost no logic

  // full-register reset images; only the stored low flag bits are taken from them
  localparam logic [7:0] FLAGS_INIT   = `TIO_FLAGS_RESET;
  localparam logic [7:0] ENABLES_INIT = `TIO_ENABLES_RESET;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  // mode and bus decode
  logic                        init;
  logic                        control_ignored;
  logic                        down_allowed;
  logic                        wr_control;
  logic                        wr_flags;
  logic                        wr_enables;
  logic                        rd_flags;

  // register contents and flag bookkeeping
  logic [`TIO_FIELD_WIDTH-1:0] role_field [1:0];
  logic [`TIO_FLAG_COUNT-1:0]  flags;
  logic [`TIO_FLAG_COUNT-1:0]  armed;
  logic [`TIO_FLAG_COUNT-1:0]  enables;
  logic [`TIO_FLAG_COUNT-1:0]  set_event;
  logic [`TIO_FLAG_COUNT-1:0]  clr_event;
  logic [`TIO_FLAG_COUNT-1:0]  next_flags;
  logic [`TIO_FLAG_COUNT-1:0]  next_armed;

  // pin sampling chain
  logic [1:0]                  sync_a;
  logic [1:0]                  sync_b;
  logic [1:0]                  pin_prev;
  logic [1:0]                  pin_now;

  // general registers as an indexed pair, and the read-back images
  logic [15:0]                 general_reg [1:0];
  logic [7:0]                  control_view;
  logic [7:0]                  flags_view;
  logic [7:0]                  enables_view;

  // ---------------------------------------------------------------
  // common strobes
  // ---------------------------------------------------------------
  // strobes act on the edge that samples them; there are no wait states
  // standby re-initialises like reset, except the pin synchronisers, so both share one term
  assign init       = reset || standby;
  assign wr_control = bus.wr && (bus.sel == `TIO_SEL_CONTROL);
  assign wr_flags   = bus.wr && (bus.sel == `TIO_SEL_FLAGS);
  assign wr_enables = bus.wr && (bus.sel == `TIO_SEL_ENABLES);
  assign rd_flags   = bus.rd && (bus.sel == `TIO_SEL_FLAGS);

  // combined pwm modes take the pins of the pair away from this logic
  assign control_ignored = IS_PAIR && mode.combined_mode_hi;

  // downward wrap only exists for up/down counting configurations
  assign down_allowed = (IS_PHASE_CH && mode.phase_count_select) ||
                        (IS_PAIR && mode.combined_mode_hi &&
                         !mode.combined_mode_lo);

  // index the two general registers so the per-register loop shares its code
  assign general_reg[0] = general_reg_a;
  assign general_reg[1] = general_reg_b;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // the chain is kept through standby, while roles, flags and outputs fall back to reset
  // first stage feeds only the second; edges compare second to third
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end

  // previous sample for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_prev <= 2'h0;
    end else begin
      pin_prev <= sync_b;
    end
  end

  // current sample seen by the edge terms
  assign pin_now = sync_b;

  // ---------------------------------------------------------------
  // per general register: role field, compare, capture, pin drive
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_reg
    // per-register decode and event terms
    logic       is_capture;
    logic [1:0] sel_low;
    logic       rise;
    logic       fall;
    logic       edge_hit;
    logic       match;

    // role field written from the bus; A takes bits 2..0, B bits 6..4
    always_ff @(posedge clk) begin
      if (init) begin
        role_field[i] <= `TIO_ROLE_RESET;
      end else if (wr_control) begin
        if (i == 0) begin
          role_field[i] <= bus.wdata[`TIO_FIELD_A_LSB +: `TIO_FIELD_WIDTH];
        end else begin
          role_field[i] <= bus.wdata[`TIO_FIELD_B_LSB +: `TIO_FIELD_WIDTH];
        end
      end
    end

    // a capture role is void while the pair is taken over by pwm
    assign is_capture = role_field[i][`TIO_ROLE_CAPTURE_BIT] && !control_ignored;
    assign sel_low    = role_field[i][1:0];

    // edge terms compare the synchronised sample with the one before it
    assign rise       = pin_now[i] && !pin_prev[i];
    assign fall       = !pin_now[i] && pin_prev[i];

    // edge selection: 00 rising, 01 falling, 1x both
    always_comb begin
      edge_hit = 1'b0;
      if (sel_low[`TIO_EDGE_BOTH_BIT]) begin
        edge_hit = rise || fall;
      end else if (sel_low == `TIO_EDGE_FALL) begin
        edge_hit = fall;
      end else begin
        edge_hit = rise;
      end
    end

    // compare only on a fresh counter value so one equality gives one event
    assign match = !is_capture && channel_counter.count_tick &&
                   (channel_counter.value == general_reg[i]);

    // capture raises a load strobe and the matching flag event
    assign set_event[i] = match || (is_capture && edge_hit);

    // the load strobe lasts one clock; the register owner latches the counter
    always_ff @(posedge clk) begin
      if (init) begin
        capture_load[i] <= 1'b0;
      end else begin
        capture_load[i] <= is_capture && edge_hit;
      end
    end

    // a capture role never moves the pin, since a match needs a compare role
    // pin drive: 0 from reset until a match changes it
    always_ff @(posedge clk) begin
      if (init) begin
        pin_out[i] <= 1'b0;
      end else if (match && !control_ignored) begin
        case (sel_low)
          `TIO_ACT_NONE:   pin_out[i] <= pin_out[i];
          `TIO_ACT_LOW:    pin_out[i] <= 1'b0;
          `TIO_ACT_HIGH:   pin_out[i] <= 1'b1;
          `TIO_ACT_TOGGLE: pin_out[i] <= NO_TOGGLE ? 1'b1 : !pin_out[i];
          default:         pin_out[i] <= pin_out[i];
        endcase
      end
    end

    // the pin is driven only in compare roles that act on it
    always_ff @(posedge clk) begin
      if (init) begin
        pin_oe[i] <= 1'b0;
      end else begin
        pin_oe[i] <= !control_ignored &&
                     !role_field[i][`TIO_ROLE_CAPTURE_BIT] &&
                     (sel_low != `TIO_ACT_NONE);
      end
    end
  end

  // ---------------------------------------------------------------
  // wrap event
  // ---------------------------------------------------------------
  // upward wraps always count; a downward one only where the counter can run down
  assign set_event[`TIO_FLAG_WRAP] = channel_counter.wrap_up ||
                                     (channel_counter.wrap_down && down_allowed);

  // ---------------------------------------------------------------
  // flag clear conditions
  // ---------------------------------------------------------------
  // a zero written clears only a flag that software saw as one
  always_comb begin
    clr_event = '0;
    if (wr_flags) begin
      clr_event = armed & ~bus.wdata[`TIO_FLAG_COUNT-1:0];
    end
    // the dma start touches flag A only, and only where the channel has it
    if (HAS_DMA_CLR && dma_start_a) begin
      clr_event[`TIO_FLAG_A] = 1'b1;
    end
  end

  // arming follows a read that saw the flag set and dies with the flag
  // set has priority, so an event in the clearing cycle survives
  always_comb begin
    next_flags = (flags & ~clr_event) | set_event;
    next_armed = armed & next_flags;
    if (rd_flags) begin
      next_armed = next_armed | flags;
    end
  end

  // ---------------------------------------------------------------
  // flag and arming state
  // ---------------------------------------------------------------
  // standby clears the flags too, so no stale event survives a wake-up
  always_ff @(posedge clk) begin
    if (init) begin
      flags <= FLAGS_INIT[`TIO_FLAG_COUNT-1:0];
    end else begin
      flags <= next_flags;
    end
  end

  // arming is lost with the flag, so a stale read cannot clear a new event
  always_ff @(posedge clk) begin
    if (init) begin
      armed <= '0;
    end else begin
      armed <= next_armed;
    end
  end

  // ---------------------------------------------------------------
  // interrupt enables and requests
  // ---------------------------------------------------------------
  // reserved enable bits are not stored; they read back as ones
  always_ff @(posedge clk) begin
    if (init) begin
      enables <= ENABLES_INIT[`TIO_FLAG_COUNT-1:0];
    end else if (wr_enables) begin
      enables <= bus.wdata[`TIO_FLAG_COUNT-1:0];
    end
  end

  // a request stands as long as both its flag and its enable are set
  // requests lag the flags by one clock to come from a flip-flop
  always_ff @(posedge clk) begin
    if (init) begin
      irq <= '0;
    end else begin
      irq.wrap <= flags[`TIO_FLAG_WRAP] && enables[`TIO_FLAG_WRAP];
      irq.b    <= flags[`TIO_FLAG_B] && enables[`TIO_FLAG_B];
      irq.a    <= flags[`TIO_FLAG_A] && enables[`TIO_FLAG_A];
    end
  end

  // ---------------------------------------------------------------
  // read-back
  // ---------------------------------------------------------------
  // the views are plain wiring; only the read path registers them
  // reserved bits are constant ones, never stored
  assign control_view = {1'b1, role_field[1], 1'b1, role_field[0]};
  assign flags_view   = {`TIO_FLAGS_FILL, flags};
  assign enables_view = {`TIO_FLAGS_FILL, enables};

  // an unmapped select reads all ones so a wrong address stands out
  // read data is registered and held until the next read
  always_ff @(posedge clk) begin
    if (init) begin
      rdata <= '0;
    end else if (bus.rd) begin
      case (bus.sel)
        `TIO_SEL_CONTROL: rdata <= control_view;
        `TIO_SEL_FLAGS:   rdata <= flags_view;
        `TIO_SEL_ENABLES: rdata <= enables_view;
        default:          rdata <= `TIO_UNMAPPED_READ;
      endcase
    end
  end

endmodule // tio_flags_ctl
`default_nettype wire

// file: bench/tio_flags_assertions.sv
// port checker for the timer pin-function and event-flag block
`timescale 1ns/1ps
`default_nettype none
`include "tio_params.svh"

module tio_flags_assertions #(
  parameter int CHANNEL_INDEX = 0
) (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic                   standby,
  // bus, counter and mode
  input wire tio_pkg::tio_bus_type   bus,
  input wire logic [7:0]             rdata,
  input wire tio_pkg::tio_count_type channel_counter,
  input wire logic [15:0]            general_reg_a,
  input wire logic [15:0]            general_reg_b,
  input wire tio_pkg::tio_mode_type  mode,
  input wire logic                   dma_start_a,
  // pins and requests
  input wire logic [1:0]             pin_in,
  input wire logic [1:0]             pin_out,
  input wire logic [1:0]             pin_oe,
  input wire logic [1:0]             capture_load,
  input wire tio_pkg::tio_irq_type   irq
);
  logic [7:0] ctl_s;
  logic [7:0] en_s;
  logic       live;
  logic       m_a;
  logic       m_b;

  // shadow of the control register, so pin checks know the selected action
  always_ff @(posedge clk) begin
    if (reset || standby) begin
      ctl_s <= `TIO_CONTROL_RESET;
    end else if (bus.wr && bus.sel == `TIO_SEL_CONTROL) begin
      ctl_s <= bus.wdata;
    end
  end

  // shadow of the enables, needed to know when a request may stand
  always_ff @(posedge clk) begin
    if (reset || standby) begin
      en_s <= `TIO_ENABLES_RESET;
    end else if (bus.wr && bus.sel == `TIO_SEL_ENABLES) begin
      en_s <= bus.wdata;
    end
  end

  // compare events; the paired pwm modes take the pins away
  assign live = !(CHANNEL_INDEX >= `TIO_CH_PAIR_LO && mode.combined_mode_hi);
  assign m_a  = channel_counter.count_tick && channel_counter.value == general_reg_a && live;
  assign m_b  = channel_counter.count_tick && channel_counter.value == general_reg_b && live;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || standby);

  // -------------------------------------------------------------
  // sequences and assertions
  // -------------------------------------------------------------
  sequence s_high_a;
    m_a && (ctl_s[2:0] == 3'h2 || (CHANNEL_INDEX == `TIO_CH_NO_TOGGLE && ctl_s[2:0] == 3'h3));
  endsequence
  sequence s_low_b;
    m_b && ctl_s[6:4] == 3'h1;
  endsequence
  sequence s_req_a;
    ##1 irq.a;
  endsequence

  a_pin_high_a : assert property (
    s_high_a |=> pin_out[0] && pin_oe[0]) else $error("pin a not driven high at match");
  a_pin_low_b : assert property (
    s_low_b |=> !pin_out[1] && pin_oe[1]) else $error("pin b not driven low at match");
  a_pin_only_match : assert property (
    $changed(pin_out[0]) |-> $past(m_a)) else $error("pin a moved without a match");
  a_match_irq_a : assert property (
    m_a && !ctl_s[2] && en_s[0] |=> s_req_a) else $error("no request after match a");
  a_wrap_irq : assert property (
    channel_counter.wrap_up && en_s[2] |=> ##1 irq.wrap) else $error("no request after wrap");
  a_irq_gated : assert property (
    (irq & ~$past(en_s[2:0])) == 3'h0) else $error("request without enable");
  a_ctl_fill : assert property (
    bus.rd && bus.sel == `TIO_SEL_CONTROL |=> rdata[7] && rdata[3]) else $error("control fill");
  a_flag_fill : assert property (
    bus.rd && bus.sel == `TIO_SEL_FLAGS |=> rdata[7:3] == 5'h1f) else $error("flag fill");
  a_rdata_hold : assert property (
    !bus.rd |=> $stable(rdata)) else $error("read data moved without a read");
  a_capture_edge : assert property (
    capture_load[0] |-> $past(pin_in[0], 3) != $past(pin_in[0], 4)) else $error("load no edge");
  a_reset_quiet : assert property (
    $fell(reset) |-> rdata == 8'h00 && pin_out == 2'h0 && irq == 3'h0) else $error("reset state");
endmodule // tio_flags_assertions

bind tio_flags_ctl tio_flags_assertions #(.CHANNEL_INDEX(CHANNEL_INDEX)) u_chk (
  .clk(clk), .reset(reset), .standby(standby), .bus(bus), .rdata(rdata),
  .channel_counter(channel_counter), .general_reg_a(general_reg_a),
  .general_reg_b(general_reg_b), .mode(mode), .dma_start_a(dma_start_a),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .capture_load(capture_load), .irq(irq));
`default_nettype wire

// file: bench/tio_cpu_model.sv
// cpu-side register bus master for the timer flag block
`timescale 1ns/1ps
`default_nettype none
`include "tio_params.svh"

module tio_cpu_model (
  // clock
  input  wire logic                 clk,
  // register bus
  output var  tio_pkg::tio_bus_type bus,
  input  wire logic [7:0]           rdata
);
  // bus idles with both strobes low
  initial bus = '0;

  // one write strobe; released data shows its inverse so stale values never look valid
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    bus.wr = 1'b1;
    bus.sel = s;
    bus.wdata = d;
    @(negedge clk);
    bus.wr = 1'b0;
    bus.wdata = ~d;
  endtask

  // one read strobe; data lands at the sampling edge and is taken a half cycle on
  task automatic rd(input logic [1:0] s, output logic [7:0] q);
    @(negedge clk);
    bus.rd = 1'b1;
    bus.sel = s;
    @(negedge clk);
    bus.rd = 1'b0;
    q = rdata;
  endtask

  // clear one flag: read it first, then write 0 to it and 1 elsewhere
  task automatic clear(input int b);
    logic [7:0] q;
    rd(`TIO_SEL_FLAGS, q);
    wr(`TIO_SEL_FLAGS, ~(8'h01 << b));
  endtask
endmodule // tio_cpu_model
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the timer pin-function and event-flag block
`timescale 1ns/1ps
`default_nettype none
`include "tio_params.svh"

module tb_top;
  logic                   clk = 1'b0;
  logic                   reset = 1'b1;
  logic                   standby = 1'b0;
  tio_pkg::tio_bus_type   bus;
  tio_pkg::tio_count_type cnt = '0;
  tio_pkg::tio_mode_type  mode = '0;
  tio_pkg::tio_irq_type   irq;
  logic [15:0]            gr = 16'h1234;
  logic                   dma = 1'b0;
  logic [1:0]             pin_in = 2'h0;
  logic [1:0]             pin_out;
  logic [1:0]             pin_oe;
  logic [1:0]             cap;
  logic [7:0]             rdata;
  logic [7:0]             q;
  int                     miscompares = 0;
  int                     checks = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  // channel 2: toggle turns into drive-high, phase wrap and dma clear apply
  tio_flags_ctl #(.CHANNEL_INDEX(2)) dut (
    .clk(clk), .reset(reset), .standby(standby), .bus(bus), .rdata(rdata),
    .channel_counter(cnt), .general_reg_a(gr), .general_reg_b(gr), .mode(mode),
    .dma_start_a(dma), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .capture_load(cap), .irq(irq));
  tio_cpu_model cpu (.clk(clk), .bus(bus), .rdata(rdata));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [1:0] s, input logic [7:0] exp);
    cpu.rd(s, q);
    chk("register", exp, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tick();
    @(negedge clk);
    cnt.count_tick = 1'b1;
    cnt.value = gr;
    @(negedge clk);
    cnt.count_tick = 1'b0;
    cyc(2);
  endtask
  task automatic wrap(input logic dn);
    @(negedge clk);
    cnt.wrap_up = !dn;
    cnt.wrap_down = dn;
    @(negedge clk);
    cnt.wrap_up = 1'b0;
    cnt.wrap_down = 1'b0;
    cyc(2);
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    rchk(`TIO_SEL_CONTROL, 8'h88);
    rchk(`TIO_SEL_FLAGS, 8'hf8);
    rchk(`TIO_SEL_ENABLES, 8'hf8);
    rchk(2'h3, 8'hff);
    chk("pins", 8'h00, {6'h00, pin_out});
    cpu.wr(`TIO_SEL_CONTROL, 8'h00);
    rchk(`TIO_SEL_CONTROL, 8'h88);
    cpu.wr(`TIO_SEL_FLAGS, 8'hff);
    rchk(`TIO_SEL_FLAGS, 8'hf8);
    $display("test reset done");
  endtask

  // actions high, none, toggle (high on this channel), low on both pins
  task automatic t_compare();
    logic [1:0] act [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
    logic       hi [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    cpu.wr(`TIO_SEL_ENABLES, 8'h03);
    for (int i = 0; i < 4; i++) begin
      cpu.wr(`TIO_SEL_CONTROL, {2'h0, act[i], 2'h0, act[i]});
      tick();
      chk("pins", {6'h00, {2{hi[i]}}}, {6'h00, pin_out});
      chk("enables", {6'h00, {2{act[i] != 2'h0}}}, {6'h00, pin_oe});
    end
    rchk(`TIO_SEL_FLAGS, 8'hfb);
    chk("irq", 8'h03, {5'h00, irq});
    cpu.clear(0);
    rchk(`TIO_SEL_FLAGS, 8'hfa);
    tick();
    @(negedge clk);
    dma = 1'b1;
    @(negedge clk);
    dma = 1'b0;
    rchk(`TIO_SEL_FLAGS, 8'hfa);
    cpu.clear(1);
    rchk(`TIO_SEL_FLAGS, 8'hf8);
    chk("irq", 8'h00, {5'h00, irq});
    $display("test compare done");
  endtask

  task automatic t_wrap();
    cpu.wr(`TIO_SEL_ENABLES, 8'h00);
    wrap(1'b0);
    chk("irq", 8'h00, {5'h00, irq});
    rchk(`TIO_SEL_FLAGS, 8'hfc);
    cpu.wr(`TIO_SEL_ENABLES, 8'h04);
    cyc(2);
    chk("irq", 8'h04, {5'h00, irq});
    cpu.clear(2);
    mode.combined_mode_hi = 1'b1;
    wrap(1'b1);
    rchk(`TIO_SEL_FLAGS, 8'hf8);
    mode.phase_count_select = 1'b1;
    wrap(1'b1);
    cpu.wr(`TIO_SEL_FLAGS, 8'hfb);
    rchk(`TIO_SEL_FLAGS, 8'hfc);
    fork
      cpu.wr(`TIO_SEL_FLAGS, 8'hfb);
      wrap(1'b0);
    join
    rchk(`TIO_SEL_FLAGS, 8'hfc);
    cpu.wr(`TIO_SEL_FLAGS, 8'hfb);
    rchk(`TIO_SEL_FLAGS, 8'hf8);
    $display("test wrap done");
  endtask

  // capture on rising, falling and both edges; both pins counted together
  task automatic t_capture();
    logic [2:0] md [4] = '{3'h4, 3'h5, 3'h6, 3'h7};
    int         n;
    for (int i = 0; i < 4; i++) begin
      cpu.wr(`TIO_SEL_CONTROL, {1'b0, md[i], 1'b0, md[i]});
      for (int e = 0; e < 2; e++) begin
        n = 0;
        @(negedge clk);
        pin_in = ~pin_in;
        repeat (8) @(negedge clk) n = n + int'(cap[0]) + int'(cap[1]);
        chk("captures", ((e == 0) ? md[i] != 3'h5 : md[i] != 3'h4) ? 8'h02 : 8'h00,
            8'(n));
      end
    end
    rchk(`TIO_SEL_FLAGS, 8'hfb);
    $display("test capture done");
  endtask

  // standby mid-run: every bus register and output falls back to its reset state
  task automatic t_standby();
    cpu.wr(`TIO_SEL_ENABLES, 8'h07);
    cpu.wr(`TIO_SEL_CONTROL, 8'h22);
    tick();
    wrap(1'b0);
    chk("pins", 8'h03, {6'h00, pin_out});
    chk("irq", 8'h07, {5'h00, irq});
    @(negedge clk);
    standby = 1'b1;
    cyc(2);
    standby = 1'b0;
    chk("pins", 8'h00, {6'h00, pin_out});
    chk("pin enables", 8'h00, {6'h00, pin_oe});
    chk("irq", 8'h00, {5'h00, irq});
    chk("rdata", 8'h00, rdata);
    rchk(`TIO_SEL_CONTROL, 8'h88);
    rchk(`TIO_SEL_FLAGS, 8'hf8);
    rchk(`TIO_SEL_ENABLES, 8'hf8);
    $display("test standby done");
  endtask

  // main sequence
  initial begin
    cyc(6);
    reset = 1'b0;
    t_reset();
    t_compare();
    t_wrap();
    t_capture();
    t_standby();
    close_out();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    miscompares++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
